// *** logic/video_label_overlay.sv ***
// Label store, APB register slave, source select and label rasterizer
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module video_label_overlay
  import label_overlay_pkg::*;
#(
  parameter int PIX_W = 10,
  parameter int FMT_W = 4
)
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [label_overlay_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FLASH_BUSY,
  input wire logic EXT_PRESENT,
  input wire logic [FMT_W-1:0] EXT_FORMAT,
  input wire logic [PIX_W-1:0] EXT_Y,
  input wire logic [PIX_W-1:0] GEN_Y,
  input wire logic VID_DE,
  input wire logic VID_LS,
  input wire logic VID_FS,
  output logic [PIX_W-1:0] VID_Y,
  output logic VID_DE_OUT,
  output logic GEN_ACTIVE,
  output logic [FMT_W-1:0] GEN_FORMAT
);
  import label_overlay_pkg::*;

  localparam logic [PIX_W-1:0] OVL_LEVEL = {2'b11, {(PIX_W - 2){1'b0}}};

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : at

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [1:0] mode, next_mode;
  logic src_gen, next_src_gen;
  logic [FMT_W-1:0] gen_fmt, next_gen_fmt;
  logic [15:0] font, next_font;
  logic page, next_page;
  logic [4:0] slot, next_slot;
  logic refused, next_refused;
  logic [LBL_LEN-1:0][7:0] label, next_label;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic setup, wr, mapped, text_wr, char_wr;
  logic [4:0] wr_ptr;
  logic [31:0] rd_value;

  always_comb
  begin
    setup = PSEL && !PENABLE;
    wr = PSEL && PENABLE && PREADY && PWRITE;
    mapped = at(PADDR, OFF_CTRL) || at(PADDR, OFF_FONT) || at(PADDR, OFF_PAGE)
             || at(PADDR, OFF_CHAR) || at(PADDR, OFF_STAT) || PADDR[LBL_WIN_BIT];
    text_wr = wr && (at(PADDR, OFF_PAGE) || at(PADDR, OFF_CHAR));
    char_wr = wr && at(PADDR, OFF_CHAR) && !FLASH_BUSY && (slot < 5'(PAGE_LEN));
    wr_ptr = {page, slot[3:0]};
    rd_value = 32'h0000_0000;
    if (PADDR[LBL_WIN_BIT])
      rd_value[7:0] = label[PADDR[6:2]];
    else if (at(PADDR, OFF_CTRL))
    begin
      rd_value[CTRL_MODE_LSB +: 2] = mode;
      rd_value[CTRL_SRC_BIT] = src_gen;
      rd_value[CTRL_FMT_LSB +: FMT_W] = gen_fmt;
    end
    else if (at(PADDR, OFF_FONT))
      rd_value[15:0] = font;
    else if (at(PADDR, OFF_PAGE))
      rd_value[5:0] = {slot, page};
    else if (at(PADDR, OFF_STAT))
    begin
      rd_value[STAT_BUSY_BIT] = FLASH_BUSY;
      rd_value[STAT_GEN_BIT] = GEN_ACTIVE;
      rd_value[STAT_REF_BIT] = refused;
    end
    next_mode = mode;
    next_src_gen = src_gen;
    next_gen_fmt = gen_fmt;
    next_font = font;
    next_page = page;
    next_slot = slot;
    next_refused = refused;
    next_label = label;
    // Zero wait states; ready registered so it drops after each access
    next_pready = setup;
    next_prdata = PRDATA;
    next_pslverr = PSLVERR;
    if (setup)
    begin
      next_prdata = rd_value;
      next_pslverr = !mapped;
    end
    if (wr && at(PADDR, OFF_CTRL))
    begin
      next_mode = PWDATA[CTRL_MODE_LSB +: 2];
      next_src_gen = PWDATA[CTRL_SRC_BIT];
      next_gen_fmt = PWDATA[CTRL_FMT_LSB +: FMT_W];
    end
    if (wr && at(PADDR, OFF_FONT) && (PWDATA[15:0] == FONT_CP1252))
      next_font = PWDATA[15:0];
    if (wr && at(PADDR, OFF_PAGE) && !FLASH_BUSY)
    begin
      next_page = PWDATA[0];
      next_slot = 5'h00;
    end
    // Only supplied positions change; the rest keep older text
    if (char_wr)
    begin
      next_label[wr_ptr] = PWDATA[7:0];
      next_slot = slot + 5'h01;
    end
    // Set wins over a same-cycle clear
    if (wr && at(PADDR, OFF_STAT) && PWDATA[STAT_REF_BIT])
      next_refused = 1'b0;
    if (text_wr && FLASH_BUSY)
      next_refused = 1'b1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      mode <= MODE_RST;
      src_gen <= 1'b0;
      gen_fmt <= FMT_RST;
      font <= FONT_RST;
      page <= 1'b0;
      slot <= 5'h00;
      refused <= 1'b0;
      label <= '0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      src_gen <= next_src_gen;
      gen_fmt <= next_gen_fmt;
      font <= next_font;
      page <= next_page;
      slot <= next_slot;
      refused <= next_refused;
      label <= next_label;
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // -----------------------------------------------------------------
  // Source select and raster position
  // -----------------------------------------------------------------
  logic gen_act;
  logic [FMT_W-1:0] last_fmt, next_last_fmt;
  logic [11:0] px, next_px;
  logic [10:0] py, next_py;
  logic [PIX_W-1:0] src_y;

  always_comb
  begin
    gen_act = src_gen || !EXT_PRESENT;
    src_y = gen_act ? GEN_Y : EXT_Y;
    // Fallback keeps the format of the last external source seen
    next_last_fmt = EXT_PRESENT ? EXT_FORMAT : last_fmt;
    next_px = px;
    next_py = py;
    if (VID_DE)
      next_px = px + 12'h001;
    if (VID_LS)
    begin
      next_px = 12'h000;
      next_py = py + 11'h001;
    end
    if (VID_FS)
      next_py = 11'h000;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      last_fmt <= FMT_RST;
      px <= 12'h000;
      py <= 11'h000;
    end
    else
    begin
      last_fmt <= next_last_fmt;
      px <= next_px;
      py <= next_py;
    end
  end

  // -----------------------------------------------------------------
  // Label rasterizer
  // -----------------------------------------------------------------
  logic [5:0] term_idx, lf_idx, base, stop, idx;
  logic in_box, vis, bit_on, glyph_hit, show;

  label_layout u_layout (
    .chars(label),
    .term_idx(term_idx),
    .lf_idx(lf_idx)
  );

  always_comb
  begin
    in_box = (py < 11'(GLYPH_H * TEXT_LINES)) && (px < 12'(GLYPH_W * LBL_LEN));
    // First text line stops at the first line feed or the terminator
    base = 6'h00;
    stop = (lf_idx < term_idx) ? lf_idx : term_idx;
    if (py[3])
    begin
      base = lf_idx + 6'h01;
      stop = (lf_idx < term_idx) ? term_idx : 6'h00;
    end
    idx = base + {1'b0, px[7:3]};
    vis = in_box && (idx < stop);
  end

  label_glyph u_glyph (
    .code(label[idx[4:0]]),
    .row(py[2:0]),
    .col(px[2:0]),
    .pix(bit_on)
  );

  always_comb
  begin
    glyph_hit = VID_DE && vis && bit_on;
    case (mode)
      MODE_EN: show = 1'b1;
      MODE_AUTO: show = gen_act;
      MODE_DIS: show = 1'b0;
      default: show = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      VID_Y <= '0;
      VID_DE_OUT <= 1'b0;
      GEN_ACTIVE <= 1'b0;
      GEN_FORMAT <= FMT_RST;
    end
    else
    begin
      VID_Y <= (show && glyph_hit) ? OVL_LEVEL : src_y;
      VID_DE_OUT <= VID_DE;
      GEN_ACTIVE <= gen_act;
      GEN_FORMAT <= src_gen ? gen_fmt : last_fmt;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_mode_on: assert property (@(posedge CLK_SYS) disable iff (RST)
    (mode == MODE_EN && glyph_hit) |=> (VID_Y == OVL_LEVEL))
    else $error("enabled mode did not draw label");
  a_mode_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    (mode == MODE_DIS) |=> (VID_Y == $past(src_y)))
    else $error("disabled mode altered video");
  a_auto_ext: assert property (@(posedge CLK_SYS) disable iff (RST)
    (mode == MODE_AUTO && !src_gen && EXT_PRESENT) |=> (VID_Y == $past(EXT_Y)))
    else $error("auto mode drew label on external video");
  a_page_store: assert property (@(posedge CLK_SYS) disable iff (RST)
    (char_wr && page) |=> (label[$past(wr_ptr)] == $past(PWDATA[7:0])) && $past(wr_ptr[4]))
    else $error("page 1 code not stored in upper half");
  a_flash_lock: assert property (@(posedge CLK_SYS) disable iff (RST)
    (text_wr && FLASH_BUSY) |=> ($stable(label) && $stable(slot) && refused))
    else $error("label changed while flash busy");
  a_term_hide: assert property (@(posedge CLK_SYS) disable iff (RST)
    glyph_hit |-> (idx < term_idx))
    else $error("character drawn past terminator");
  a_line_two: assert property (@(posedge CLK_SYS) disable iff (RST)
    (vis && py[3]) |-> (lf_idx < term_idx) && (idx > lf_idx))
    else $error("second line without first line feed");
  a_font_keep: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr && at(PADDR, OFF_FONT) && PWDATA[15:0] != FONT_CP1252) |=> $stable(font))
    else $error("unsupported font accepted");
  a_fallback: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!EXT_PRESENT) |=> GEN_ACTIVE ##0 (VID_Y == $past(GEN_Y) || VID_Y == OVL_LEVEL))
    else $error("generator not driving on lost input");
endmodule : video_label_overlay

// *** logic/label_overlay_pkg.sv ***
// Shared constants for the video label overlay
package label_overlay_pkg;
  // -----------------------------------------------------------------
  // Register map (byte addresses)
  // -----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FONT = 8'h04;
  localparam logic [7:0] OFF_PAGE = 8'h08;
  localparam logic [7:0] OFF_CHAR = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  // Label readback window: any address with bit 7 set, word index in [6:2]
  localparam int LBL_WIN_BIT = 7;
  // -----------------------------------------------------------------
  // Fields
  // -----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_FMT_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_GEN_BIT = 1;
  localparam int STAT_REF_BIT = 2;
  localparam logic [1:0] MODE_DIS = 2'h0;
  localparam logic [1:0] MODE_EN = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  // -----------------------------------------------------------------
  // Values after reset and fixed codes
  // -----------------------------------------------------------------
  localparam logic [1:0] MODE_RST = MODE_DIS;
  localparam logic [15:0] FONT_CP1252 = 16'h04E4;
  localparam logic [15:0] FONT_RST = FONT_CP1252;
  localparam logic [3:0] FMT_RST = 4'h0;
  localparam logic [7:0] CHAR_NUL = 8'h00;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_DEL = 8'h7F;
  localparam int LBL_LEN = 32;
  localparam int PAGE_LEN = 16;
  localparam int GLYPH_W = 8;
  localparam int GLYPH_H = 8;
  localparam int TEXT_LINES = 2;
endpackage : label_overlay_pkg

// *** logic/label_glyph.sv ***
// Glyph generator for one label character cell
`timescale 1ns/1ns
module label_glyph
  import label_overlay_pkg::*;
(
  input wire logic [7:0] code,
  input wire logic [2:0] row,
  input wire logic [2:0] col,
  output logic pix
);
  logic printable;
  // Procedural stand-in for the code page 1252 bitmap table; control
  // codes, including surplus line feeds, draw as blank cells
  always_comb
  begin
    printable = (code >= CHAR_SPACE) && (code != CHAR_DEL);
    pix = printable && (row != 3'h0) && (row != 3'h7) && (col != 3'h7)
          && (code[col] ^ row[0]);
  end
endmodule : label_glyph

// *** logic/label_layout.sv ***
// Finds the string end and the first line feed in the stored label
`timescale 1ns/1ns
module label_layout
  import label_overlay_pkg::*;
(
  input wire logic [31:0][7:0] chars,
  output logic [5:0] term_idx,
  output logic [5:0] lf_idx
);
  // Scan downward so the lowest position wins; 32 means none found
  always_comb
  begin
    term_idx = 6'(LBL_LEN);
    lf_idx = 6'(LBL_LEN);
    for (int i = LBL_LEN - 1; i >= 0; i--)
    begin
      if (chars[i] == CHAR_NUL)
        term_idx = 6'(i);
      if (chars[i] == CHAR_LF)
        lf_idx = 6'(i);
    end
  end
endmodule : label_layout

// *** verif/ctrl_model.sv ***
// Card controller model: APB master that issues label commands
`timescale 1ns/1ns
module ctrl_model
  import label_overlay_pkg::*;
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Request is held until pready is sampled high; only then released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No cycle limit here; a hung slave is caught by the bench watchdog
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // At most one page of characters per command, plus one terminator code when term is set
  task page_write(input logic pg, input string s, input bit term);
    logic [31:0] r;
    logic e;
    xfer(1'b1, OFF_PAGE, {31'h0, pg}, r, e);
    for (int i = 0; i < s.len() && i < PAGE_LEN; i++)
      xfer(1'b1, OFF_CHAR, {24'h0, s[i]}, r, e);
    if (term)
      xfer(1'b1, OFF_CHAR, {24'h0, CHAR_NUL}, r, e);
  endtask : page_write
endmodule : ctrl_model

// *** verif/video_label_overlay_test.sv ***
// Self-checking bench for the video label overlay
`timescale 1ns/1ns
module video_label_overlay_test;
  import label_overlay_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, flash_busy, ext_present;
  logic vid_de, vid_ls, vid_fs, vid_de_out, gen_active, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] ext_format, gen_format, fmt;
  logic [9:0] ext_y, gen_y, vid_y;
  logic [1:0] mds [5] = '{MODE_DIS, MODE_EN, MODE_AUTO, MODE_AUTO, MODE_DIS};
  bit srcs [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  int seed = 96;
  int err_total, checked, c0, c1, line, a, b;

  video_label_overlay DUT (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FLASH_BUSY(flash_busy), .EXT_PRESENT(ext_present),
    .EXT_FORMAT(ext_format), .EXT_Y(ext_y), .GEN_Y(gen_y), .VID_DE(vid_de),
    .VID_LS(vid_ls), .VID_FS(vid_fs), .VID_Y(vid_y), .VID_DE_OUT(vid_de_out),
    .GEN_ACTIVE(gen_active), .GEN_FORMAT(gen_format));
  ctrl_model m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Sampled mid-cycle, away from the launching edge
  always @(negedge clk)
    if (vid_de_out === 1'b1 && vid_y === 10'h300)
    begin
      if (line < 8)
        c0++;
      else if (line < 16)
        c1++;
    end

  function automatic bit shown(logic [1:0] md, bit src);
    return md == MODE_EN || (md == MODE_AUTO && src);
  endfunction : shown

  task chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task chk_px(string nm, bit exp, int got);
    checked++;
    if ((got > 0) != exp)
    begin
      err_total++;
      $display("unexpected %s: expected drawn %0d, seen %0d pixels", nm, exp, got);
    end
  endtask : chk_px

  task chk_lbl(int i, logic [7:0] exp);
    m.xfer(1'b0, 8'h80 | 8'(i << 2), 32'h0, r, e);
    chk("label code", 32'(exp), r);
  endtask : chk_lbl

  // Seventeen lines; only the first sixteen can hold the label box
  task frame;
    c0 = 0;
    c1 = 0;
    for (int l = 0; l < 17; l++)
    begin
      @(posedge clk);
      vid_ls <= 1'b1;
      vid_fs <= (l == 0);
      line <= l;
      @(posedge clk);
      vid_ls <= 1'b0;
      vid_fs <= 1'b0;
      repeat (260)
      begin
        @(posedge clk);
        vid_de <= 1'b1;
        ext_y <= 10'($random(seed)) & 10'h1FF;
        gen_y <= 10'($random(seed)) & 10'h1FF;
      end
      @(posedge clk);
      vid_de <= 1'b0;
      repeat (3) @(posedge clk);
    end
    a = c0;
    b = c1;
  endtask : frame

  task complete_run;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    {flash_busy, vid_de, vid_ls, vid_fs, ext_y, gen_y, ext_format} = '0;
    ext_present = 1'b1;
    line = 99;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    m.xfer(1'b0, OFF_FONT, 32'h0, r, e);
    chk("font", 32'(FONT_CP1252), r);
    m.xfer(1'b1, OFF_FONT, 32'h1234, r, e);
    m.xfer(1'b0, OFF_FONT, 32'h0, r, e);
    chk("font kept", 32'(FONT_CP1252), r);
    m.xfer(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
    $display("test registers done");
    m.page_write(1'b0, "ABC", 1'b0);
    m.page_write(1'b1, "XYXYXYXYXYXYXYXY", 1'b1);
    chk_lbl(2, 8'h43);
    chk_lbl(16, 8'h58);
    chk_lbl(17, 8'h59);
    chk_lbl(31, 8'h59);
    m.xfer(1'b0, OFF_PAGE, 32'h0, r, e);
    chk("page pointer", 32'h21, r);
    m.page_write(1'b0, "Q", 1'b0);
    chk_lbl(0, 8'h51);
    chk_lbl(1, 8'h42);
    $display("test pages done");
    flash_busy <= 1'b1;
    m.page_write(1'b0, "Z", 1'b0);
    chk_lbl(0, 8'h51);
    m.xfer(1'b0, OFF_STAT, 32'h0, r, e);
    chk("refused flag", 32'h1, 32'(r[STAT_REF_BIT]));
    chk("busy flag", 32'h1, 32'(r[STAT_BUSY_BIT]));
    flash_busy <= 1'b0;
    m.xfer(1'b1, OFF_STAT, 32'h4, r, e);
    m.xfer(1'b0, OFF_STAT, 32'h0, r, e);
    chk("refused cleared", 32'h0, 32'(r[STAT_REF_BIT]));
    $display("test flash done");
    fmt = 4'($random(seed));
    ext_format <= fmt;
    repeat (3) @(posedge clk);
    chk("generator idle", 32'h0, 32'(gen_active));
    ext_present <= 1'b0;
    ext_format <= ~fmt;
    repeat (3) @(posedge clk);
    chk("generator fallback", 32'h1, 32'(gen_active));
    chk("fallback format", 32'(fmt), 32'(gen_format));
    m.xfer(1'b1, OFF_CTRL, {24'h0, fmt ^ 4'h5, 4'h4}, r, e);
    repeat (2) @(posedge clk);
    chk("generator format", 32'(fmt ^ 4'h5), 32'(gen_format));
    ext_present <= 1'b1;
    $display("test source done");
    for (int k = 0; k < 5; k++)
    begin
      m.xfer(1'b1, OFF_CTRL, {29'h0, srcs[k], mds[k]}, r, e);
      frame();
      chk_px("label pixels", shown(mds[k], srcs[k]), a + b);
    end
    $display("test modes done");
    m.xfer(1'b1, OFF_CTRL, {30'h0, MODE_EN}, r, e);
    m.page_write(1'b0, "\nA", 1'b1);
    frame();
    chk_px("first text line", 1'b0, a);
    chk_px("second text line", 1'b1, b);
    m.page_write(1'b0, "", 1'b1);
    frame();
    chk_px("after terminator", 1'b0, a + b);
    $display("test layout done");
    complete_run();
  end
endmodule : video_label_overlay_test
